// ===== rtl/fpp_defs.vh
`ifndef FPP_DEFS_VH
`define FPP_DEFS_VH

// Bus mode codes.
`define FPP_MODE_STANDBY    3'h0
`define FPP_MODE_READ       3'h1
`define FPP_MODE_OUTDIS     3'h2
`define FPP_MODE_WRITE      3'h3
`define FPP_MODE_DEEPPD     3'h4

// Software command codes.
`define FPP_CMD_READ_ARRAY  8'hFF
`define FPP_CMD_READ_STATUS 8'h70
`define FPP_CMD_CLEAR_STAT  8'h50
`define FPP_CMD_PROGRAM     8'h40
`define FPP_CMD_ERASE       8'h20
`define FPP_CMD_ERASE_ALL   8'h20
`define FPP_CMD_BLOCK_CONF  8'hD0

// Area bases and sizes.
`define FPP_USER_BASE       16'h8000
`define FPP_BOOT_BASE       16'hF000
`define FPP_BOOT_MASK       16'h0FFF
`define FPP_USER_MASK       16'h7FFF
`define FPP_BLOCK_MASK      16'h7C00

// Status register layout and reset value.
`define FPP_STATUS_RESET    8'h80
`define FPP_SR_READY_BIT    7
`define FPP_SR_ERASE_BIT    5
`define FPP_SR_PROG_BIT     4

// Operation times in cycles of the 10 MHz clock.
`define FPP_PROG_CYCLES     16'h0010
`define FPP_ERASE_CYCLES    16'h0100

`endif

// ===== rtl/fpp_sync.v
`default_nettype none

// Two-flop synchroniser, one per bit.
module fpp_sync #(
    parameter WIDTH = 4
) (
    input  wire             ref_clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // Reset to the inactive (high) level of the active-low strobes.
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_r <= {WIDTH{1'b1}};
            sync_r <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

`default_nettype wire

// ===== rtl/fpp_port.v
`include "fpp_defs.vh"
`default_nettype none

// Overview of operation
// - area_select low picks the user area, high the boot area.
// - Program acts only in the user area; erase acts in both areas.
// - User area is 32 Kbytes at 8000h to FFFFh.
// - Boot area is 4 Kbytes at F000h to FFFFh.
// - Boot erase treats the whole boot area as one block.
// - Chip select and gate low, write and power-down high drive read data.
// - Read data is array or status, chosen by the last command.
// - Array reading is selected at power-on and leaving deep power-down.
// - Chip select low, others high floats the data pins.
// - Chip select high with power-down high is standby, pins float.
// - Raising chip select never aborts a running program or erase.
// - Chip select and write low, gate and power-down high accept commands or write data.
// - Address, command and data latch on the first rising strobe.
// - Operations run only on commands; reads return what commands chose.
// - Address arrives as two bytes; data is one bidirectional byte.
// - Power-down low floats pins and cancels a running operation.
// - ready_busy_out is low while busy, tracks the sequencer ready flag.
// - Status register reads 80h at power-on and after deep power-down.
module fpp_port #(
    parameter AW     = 16,
    parameter DEPTH  = 32768
) (
    input  wire         ref_clk,
    input  wire         rst_n,
    input  wire [7:0]   address_lo_pins,
    input  wire [7:0]   address_hi_pins,
    input  wire [7:0]   data_pins_in,
    output reg  [7:0]   data_pins_out,
    output reg          data_pins_oe,
    input  wire         chip_sel_n,
    input  wire         out_gate_n,
    input  wire         write_n,
    input  wire         power_down_n,
    input  wire         area_select,
    output reg          ready_busy_out,
    output reg  [2:0]   bus_mode
);

    localparam ST_IDLE   = 2'h0;
    localparam ST_PROG   = 2'h1;
    localparam ST_ERASE  = 2'h2;
    localparam ST_WAIT2  = 2'h3;

    wire [3:0]  strobes_s;
    wire        cs_n_s;
    wire        oe_n_s;
    wire        we_n_s;
    wire        pd_n_s;
    reg  [7:0]  addr_lo_m_r;
    reg  [7:0]  addr_lo_s_r;
    reg  [7:0]  addr_hi_m_r;
    reg  [7:0]  addr_hi_s_r;
    reg  [7:0]  data_m_r;
    reg  [7:0]  data_s_r;
    reg         area_select_m_r;
    reg         area_select_s_r;
    reg         wr_active_r;
    reg  [15:0] cap_addr_r;
    reg  [7:0]  cap_data_r;
    reg         cap_area_r;
    reg  [1:0]  state_r;
    reg  [7:0]  pend_cmd_r;
    reg         read_status_r;
    reg  [7:0]  status_r;
    reg  [15:0] op_cnt_r;
    reg  [15:0] op_addr_r;
    reg  [7:0]  op_data_r;
    reg         op_erase_all_r;
    reg  [15:0] erase_idx_r;
    reg  [15:0] erase_last_r;
    reg         op_boot_r;
    reg  [7:0]  user_mem [0:DEPTH-1];
    reg  [7:0]  boot_mem [0:4095];
    reg  [2:0]  mode_nxt;
    wire        wr_done;
    wire [7:0]  cmd;
    wire        err_set;
    wire        user_ok;

    fpp_sync #(
        .WIDTH (4)
    ) fpp_sync_inst (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .async_in ({chip_sel_n, out_gate_n, write_n, power_down_n}),
        .sync_out (strobes_s)
    );

    assign cs_n_s = strobes_s[3];
    assign oe_n_s = strobes_s[2];
    assign we_n_s = strobes_s[1];
    assign pd_n_s = strobes_s[0];

    // Address, data and area pins are synchronised too; they are held stable
    // around the strobe edge, so the two-cycle lag matches the strobes.
    always @(posedge ref_clk)
    begin
        addr_lo_m_r <= address_lo_pins;
        addr_lo_s_r <= addr_lo_m_r;
        addr_hi_m_r <= address_hi_pins;
        addr_hi_s_r <= addr_hi_m_r;
        data_m_r    <= data_pins_in;
        data_s_r    <= data_m_r;
        area_select_m_r    <= area_select;
        area_select_s_r    <= area_select_m_r;
    end

    // bus mode decode from synchronised strobes
    always @*
    begin
        if (!pd_n_s)
            mode_nxt = `FPP_MODE_DEEPPD;
        else if (cs_n_s)
            mode_nxt = `FPP_MODE_STANDBY;
        else if (!we_n_s && oe_n_s)
            mode_nxt = `FPP_MODE_WRITE;
        else if (!oe_n_s && we_n_s)
            mode_nxt = `FPP_MODE_READ;
        else
            mode_nxt = `FPP_MODE_OUTDIS;
    end

    // write cycle ends at whichever of write or chip select rises first.
    assign wr_done = wr_active_r && (we_n_s || cs_n_s);
    assign cmd     = cap_data_r;

    // Address and data are sampled throughout the write cycle; the last
    // sample before the first rising strobe is the latched value.
    always @(posedge ref_clk)
    begin
        if (!rst_n || !pd_n_s)
            wr_active_r <= 1'b0;
        else
            wr_active_r <= (mode_nxt == `FPP_MODE_WRITE);
        if (mode_nxt == `FPP_MODE_WRITE)
        begin
            cap_addr_r <= {addr_hi_s_r, addr_lo_s_r};
            cap_data_r <= data_s_r;
            cap_area_r <= area_select_s_r;
        end
    end

    // addresses below the user base are outside the user area.
    assign user_ok = (cap_addr_r >= `FPP_USER_BASE) && !cap_area_r;
    assign err_set = (status_r[`FPP_SR_ERASE_BIT] || status_r[`FPP_SR_PROG_BIT]);

    // Command sequencer with program and erase timers.
    always @(posedge ref_clk)
    begin
        // reset and deep power-down restore array read
        if (!rst_n || !pd_n_s)
        begin
            state_r        <= ST_IDLE;
            pend_cmd_r     <= 8'h00;
            read_status_r  <= 1'b0;
            status_r       <= `FPP_STATUS_RESET;
            op_cnt_r       <= 16'h0000;
            op_addr_r      <= 16'h0000;
            op_data_r      <= 8'h00;
            op_erase_all_r <= 1'b0;
            op_boot_r      <= 1'b0;
            erase_idx_r    <= 16'h0000;
            erase_last_r   <= 16'h0000;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    // commands accepted only at the end of a write cycle
                    if (wr_done)
                    begin
                        case (cmd)
                            `FPP_CMD_READ_ARRAY:  read_status_r <= 1'b0;
                            `FPP_CMD_READ_STATUS: read_status_r <= 1'b1;
                            `FPP_CMD_CLEAR_STAT:
                            begin
                                status_r[`FPP_SR_ERASE_BIT] <= 1'b0;
                                status_r[`FPP_SR_PROG_BIT]  <= 1'b0;
                            end
                            `FPP_CMD_PROGRAM, `FPP_CMD_ERASE:
                            begin
                                pend_cmd_r <= cmd;
                                state_r    <= ST_WAIT2;
                            end
                            default:
                            begin
                                status_r[`FPP_SR_ERASE_BIT] <= 1'b1;
                                status_r[`FPP_SR_PROG_BIT]  <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_WAIT2:
                begin
                    if (wr_done)
                    begin
                        read_status_r <= 1'b1;
                        state_r       <= ST_IDLE;
                        // program only inside the user area
                        if (pend_cmd_r == `FPP_CMD_PROGRAM && !err_set && user_ok)
                        begin
                            op_addr_r <= cap_addr_r;
                            op_data_r <= cmd;
                            op_cnt_r  <= `FPP_PROG_CYCLES;
                            status_r[`FPP_SR_READY_BIT] <= 1'b0;
                            state_r   <= ST_PROG;
                        end
                        else if (pend_cmd_r == `FPP_CMD_ERASE && !err_set &&
                                 (cmd == `FPP_CMD_ERASE_ALL || cmd == `FPP_CMD_BLOCK_CONF))
                        begin
                            // boot area is one block; user block ends at given address
                            op_boot_r      <= cap_area_r;
                            op_erase_all_r <= (cmd == `FPP_CMD_ERASE_ALL);
                            erase_last_r   <= cap_area_r ? `FPP_BOOT_MASK :
                                              (cmd == `FPP_CMD_ERASE_ALL) ? `FPP_USER_MASK :
                                              (cap_addr_r - `FPP_USER_BASE);
                            erase_idx_r    <= (cap_area_r || cmd == `FPP_CMD_ERASE_ALL) ? 16'h0000 :
                                              ((cap_addr_r - `FPP_USER_BASE) & `FPP_BLOCK_MASK);
                            op_cnt_r       <= `FPP_ERASE_CYCLES;
                            status_r[`FPP_SR_READY_BIT] <= 1'b0;
                            state_r        <= ST_ERASE;
                        end
                        else
                        begin
                            status_r[`FPP_SR_ERASE_BIT] <= 1'b1;
                            status_r[`FPP_SR_PROG_BIT]  <= 1'b1;
                        end
                    end
                end
                // runs to completion regardless of chip select
                ST_PROG:
                begin
                    if (op_cnt_r == 16'h0000)
                    begin
                        status_r[`FPP_SR_READY_BIT] <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                    else
                        op_cnt_r <= op_cnt_r - 16'h0001;
                end
                ST_ERASE:
                begin
                    if (op_cnt_r != 16'h0000)
                        op_cnt_r <= op_cnt_r - 16'h0001;
                    else if (erase_idx_r == erase_last_r)
                    begin
                        status_r[`FPP_SR_READY_BIT] <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                    else
                        erase_idx_r <= erase_idx_r + 16'h0001;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Memory writes: program clears bits, erase sets bytes to FFh.
    always @(posedge ref_clk)
    begin
        if (rst_n && pd_n_s && state_r == ST_PROG && op_cnt_r == 16'h0000)
            user_mem[op_addr_r[14:0]] <= user_mem[op_addr_r[14:0]] & op_data_r;
        if (rst_n && pd_n_s && state_r == ST_ERASE && op_cnt_r == 16'h0000)
        begin
            if (op_boot_r)
                boot_mem[erase_idx_r[11:0]] <= 8'hFF;
            else
                user_mem[erase_idx_r[14:0]] <= 8'hFF;
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            data_pins_out  <= 8'h00;
            data_pins_oe   <= 1'b0;
            ready_busy_out <= 1'b1;
            bus_mode       <= `FPP_MODE_STANDBY;
        end
        else
        begin
            bus_mode       <= mode_nxt;
            ready_busy_out <= status_r[`FPP_SR_READY_BIT];
            data_pins_oe   <= (mode_nxt == `FPP_MODE_READ);
            if (read_status_r)
                data_pins_out <= status_r;
            else if (area_select_s_r)
                data_pins_out <= ({addr_hi_s_r, addr_lo_s_r} >= `FPP_BOOT_BASE) ?
                                 boot_mem[{addr_hi_s_r[3:0], addr_lo_s_r}] : 8'hFF;
            else
                data_pins_out <= addr_hi_s_r[7] ? user_mem[{addr_hi_s_r[6:0], addr_lo_s_r}] : 8'hFF;
        end
    end

endmodule

`default_nettype wire

// ===== sim/fpp_port_properties.sv
`default_nettype none
// Watches the port pins; a strobe change needs two edges to reach the mode decoder.
module fpp_port_properties (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       chip_sel_n,
    input wire logic       out_gate_n,
    input wire logic       write_n,
    input wire logic       power_down_n,
    input wire logic       data_pins_oe,
    input wire logic       ready_busy_out,
    input wire logic [2:0] bus_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] busy_cnt_r;
    logic [23:0] busy_cnt_nxt;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Length of the current busy stretch, so a hung sequencer shows up.
    assign busy_cnt_nxt = ready_busy_out ? 24'h000000 : busy_cnt_r + 24'h000001;
    always_ff @(posedge ref_clk)
        busy_cnt_r <= rst_n ? busy_cnt_nxt : 24'h000000;
    sequence s_read_held;
        (!chip_sel_n && !out_gate_n && write_n && power_down_n) [*5];
    endsequence
    sequence s_outdis_held;
        (!chip_sel_n && out_gate_n && write_n && power_down_n) [*5];
    endsequence
    sequence s_write_held;
        (!chip_sel_n && out_gate_n && !write_n && power_down_n) [*5];
    endsequence
    a_read_drives_pins: assert property (s_read_held |-> data_pins_oe && bus_mode == 3'h1)
        else $error("read mode not driving data pins");
    a_outdis_floats: assert property (s_outdis_held |-> !data_pins_oe && bus_mode == 3'h2)
        else $error("output disable mode wrong");
    a_standby_floats: assert property ((chip_sel_n && power_down_n) [*5] |-> !data_pins_oe && bus_mode == 3'h0)
        else $error("standby mode wrong");
    a_write_mode_seen: assert property (s_write_held |-> !data_pins_oe && bus_mode == 3'h3)
        else $error("write mode wrong");
    a_deep_pd_idle: assert property ((!power_down_n) [*5] |-> !data_pins_oe && bus_mode == 3'h4 && ready_busy_out)
        else $error("deep power-down mode wrong");
    a_gate_high_floats: assert property (out_gate_n [*5] |-> !data_pins_oe)
        else $error("pins driven with gate high");
    a_busy_needs_power: assert property ($fell(ready_busy_out) |-> $past(power_down_n, 1))
        else $error("busy started in power-down");
    a_busy_bounded: assert property (busy_cnt_r <= 24'h800100)
        else $error("busy stretch too long");
endmodule
`default_nettype wire

// ===== sim/fpp_programmer.sv
`default_nettype none
// External programmer; strobes change at the falling edge and each phase is held five cycles.
module fpp_programmer (
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_bus,
    output var  logic [7:0] addr_lo,
    output var  logic [7:0] addr_hi,
    output var  logic [7:0] drv_data,
    output var  logic       drv_en,
    output var  logic       cs_n,
    output var  logic       og_n,
    output var  logic       we_n,
    output var  logic       pd_n,
    output var  logic       area_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle pins at time zero.
    initial
    begin
        {addr_hi, addr_lo, drv_data, drv_en} = 25'h0000000;
        {cs_n, og_n, we_n, pd_n, area_sel} = 5'h1E;
    end
    task automatic pins(input logic [3:0] p);
        @(negedge ref_clk);
        {cs_n, og_n, we_n, pd_n} = p;
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {addr_hi, addr_lo} = a;
        drv_data = d;
        drv_en = 1'b1;
        pins(4'h5); // Write strobe low, then raise it first so data is still held.
        pins(4'h7);
        pins(4'hF);
        drv_en = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        {addr_hi, addr_lo} = a;
        pins(4'h3);
        d = data_bus;
        pins(4'hF);
    endtask
endmodule
`default_nettype wire

// ===== sim/fpp_port_tb_top.sv
`default_nettype none
module fpp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] addr_lo, addr_hi, drv_data, data_pins_out, v;
    logic [7:0] last_val = 8'h00;
    logic       drv_en, data_pins_oe, cs_n, og_n, we_n, pd_n, area_sel, ready_busy_out;
    logic [2:0] bus_mode;
    wire  [7:0] data_bus;
    int         fails = 0;
    int         n_checks = 0;
    int         cycles = 0;
    // A floating bus shows the inverse of its last value, never a lucky match.
    assign data_bus = data_pins_oe ? data_pins_out : drv_en ? drv_data : ~last_val;
    fpp_port fpp_port_inst (.ref_clk(ref_clk), .rst_n(rst_n), .address_lo_pins(addr_lo), .address_hi_pins(addr_hi),
        .data_pins_in(data_bus), .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe), .chip_sel_n(cs_n),
        .out_gate_n(og_n), .write_n(we_n), .power_down_n(pd_n), .area_select(area_sel),
        .ready_busy_out(ready_busy_out), .bus_mode(bus_mode));
    fpp_programmer fpp_programmer_inst (.ref_clk(ref_clk), .data_bus(data_bus), .addr_lo(addr_lo),
        .addr_hi(addr_hi), .drv_data(drv_data), .drv_en(drv_en), .cs_n(cs_n), .og_n(og_n), .we_n(we_n),
        .pd_n(pd_n), .area_sel(area_sel));
    // Clock, bus memory and the hang limit.
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        if (data_pins_oe || drv_en)
            last_val <= data_bus;
        cycles++;
        if (cycles == 8000)
        begin
            fails++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_ready(input logic lvl, input int limit);
        int n = 0;
        while (ready_busy_out !== lvl && n < limit)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("ready_busy_out", {7'h00, lvl}, {7'h00, ready_busy_out});
    endtask
    task automatic status_is(input logic [7:0] exp);
        fpp_programmer_inst.wr(16'h8000, 8'h70);
        fpp_programmer_inst.rd(16'h8000, v);
        check("status", exp, v);
    endtask
    // One pin combination for each bus mode; the write is ended by power-down, so no command is taken.
    task automatic t_modes();
        logic [3:0] p [5] = '{4'h9, 4'h3, 4'h7, 4'h5, 4'h0};
        logic [2:0] m [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
        fpp_programmer_inst.drv_data = 8'hFF;
        for (int i = 0; i < 5; i++)
        begin
            fpp_programmer_inst.pins(p[i]);
            check("bus_mode", {5'h00, m[i]}, {5'h00, bus_mode});
            check("data_pins_oe", {7'h00, i == 1}, {7'h00, data_pins_oe});
        end
        fpp_programmer_inst.pins(4'hF);
    endtask
    // Program in the user area, chip select released while busy.
    task automatic t_program();
        fpp_programmer_inst.wr(16'h8000, 8'h50);
        fpp_programmer_inst.wr(16'h8000, 8'h40);
        fpp_programmer_inst.wr(16'h8005, 8'hA5);
        wait_ready(1'b0, 8);
        wait_ready(1'b1, 40);
        fpp_programmer_inst.rd(16'h8000, v);
        check("status after program", 8'h80, v);
    endtask
    // Boot-area program, locked program and an unknown code are all refused.
    task automatic t_refusals();
        fpp_programmer_inst.area_sel = 1'b1;
        fpp_programmer_inst.wr(16'hF000, 8'h40);
        fpp_programmer_inst.wr(16'hF010, 8'h00);
        check("ready boot", 8'h01, {7'h00, ready_busy_out});
        fpp_programmer_inst.area_sel = 1'b0;
        status_is(8'hB0);
        fpp_programmer_inst.wr(16'h8000, 8'h40);
        fpp_programmer_inst.wr(16'h8006, 8'h00);
        check("ready locked", 8'h01, {7'h00, ready_busy_out});
        fpp_programmer_inst.wr(16'h8000, 8'h50);
        status_is(8'h80);
        fpp_programmer_inst.wr(16'h8000, 8'h99);
        status_is(8'hB0);
        fpp_programmer_inst.wr(16'h8000, 8'h50);
    endtask
    // User block erase, program over it, then a whole boot erase; array reads judge each.
    task automatic t_erase();
        fpp_programmer_inst.wr(16'h8000, 8'h20);
        fpp_programmer_inst.wr(16'h83FF, 8'hD0);
        wait_ready(1'b0, 8);
        wait_ready(1'b1, 1400);
        fpp_programmer_inst.wr(16'h8000, 8'hFF);
        fpp_programmer_inst.rd(16'h8005, v);
        check("erased byte", 8'hFF, v);
        fpp_programmer_inst.wr(16'h8000, 8'h40);
        fpp_programmer_inst.wr(16'h8005, 8'h5A);
        wait_ready(1'b1, 40);
        fpp_programmer_inst.wr(16'h8000, 8'hFF);
        fpp_programmer_inst.rd(16'h8005, v);
        check("programmed byte", 8'h5A, v);
        fpp_programmer_inst.area_sel = 1'b1;
        fpp_programmer_inst.wr(16'hF000, 8'h20);
        fpp_programmer_inst.wr(16'hFFFF, 8'h20);
        wait_ready(1'b0, 8);
        wait_ready(1'b1, 4500);
        fpp_programmer_inst.wr(16'hF000, 8'hFF);
        fpp_programmer_inst.rd(16'hFABC, v);
        check("boot byte", 8'hFF, v);
        fpp_programmer_inst.area_sel = 1'b0;
    endtask
    // Power-down in mid-program cancels it and restores the status value.
    task automatic t_pd_cancel();
        fpp_programmer_inst.wr(16'h8000, 8'h40);
        fpp_programmer_inst.wr(16'h8007, 8'h00);
        wait_ready(1'b0, 8);
        fpp_programmer_inst.pins(4'hE);
        check("ready pd", 8'h01, {7'h00, ready_busy_out});
        check("mode pd", 8'h04, {5'h00, bus_mode});
        fpp_programmer_inst.pins(4'hF);
        fpp_programmer_inst.rd(16'h8010, v);
        check("array after power-down", 8'hFF, v);
        status_is(8'h80);
    endtask
    // Main sequence.
    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        status_is(8'h80);
        t_modes();
        t_program();
        t_refusals();
        t_erase();
        t_pd_cancel();
        stop_test();
    end
endmodule
bind fpp_port fpp_port_properties fpp_port_properties_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .write_n(write_n), .power_down_n(power_down_n),
    .data_pins_oe(data_pins_oe), .ready_busy_out(ready_busy_out), .bus_mode(bus_mode));
`default_nettype wire
